// file: common/sfsf_pkg.sv
// Notes on behaviour
// - Status register is 16 bits, read/write
// - Writing one never sets a flag
// - Zero clears only after flag read as one
// - Transmit-end, framing, parity flags are read-only
// - Bits 15 to 10 read zero
// - Overrun flag at bit 9, resets zero
// - Overrun set when character completes, FIFO full; here only in async mode with receive enabled
// - Both flags cleared by either reset
// - Receive-enable low keeps overrun flag
// - Transmit-stop at bit 8 set on count match
// - Software clears transmit-stop by read-then-zero
package sfsf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SERIAL_STATUS_ADDR = 8'h00;
  localparam logic [7:0] STOP_COUNT_ADDR = 8'h04;
  localparam logic [7:0] CONTROL_ADDR = 8'h08;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
  localparam logic [7:0] FIFO_DATA_ADDR = 8'h14;
  localparam logic [7:0] TX_COUNT_ADDR = 8'h18;
  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int STATUS_W = 16;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 8;
  localparam int OVERRUN_BIT = 9;
  localparam int TX_STOP_BIT = 8;
  localparam int RX_ERR_BIT = 7;
  localparam int TX_END_BIT = 6;
  localparam int TX_EMPTY_BIT = 5;
  localparam int BREAK_BIT = 4;
  localparam int FRAMING_BIT = 3;
  localparam int PARITY_BIT = 2;
  localparam int RX_FULL_BIT = 1;
  localparam int DATA_READY_BIT = 0;
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_ASYNC_BIT = 1;
  localparam int IRQ_OVERRUN_BIT = 0;
  localparam int IRQ_TX_STOP_BIT = 1;
  localparam logic [15:0] CLEARABLE_MASK = 16'h03B3;
  localparam logic [15:0] STATUS_RESET = 16'h0040;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam int FIFO_DEPTH = 16;
endpackage : sfsf_pkg

// file: rtl/sfsf_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sfsf_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage_reg;

  // Three-stage capture; change taken once last two agree
  // Reset to the line's idle level so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage_reg <= {3{RESET_VAL}};
      dout <= RESET_VAL;
    end else begin
      stage_reg <= {stage_reg[1:0], din};
      if (stage_reg[2] == stage_reg[1]) begin
        dout <= stage_reg[2];
      end
    end
  end
endmodule : sfsf_sync
`default_nettype wire

// file: rtl/sfsf_rx_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module sfsf_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_pop,
  output logic [WIDTH-1:0] rd_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  // Full FIFO refuses the write so older data is kept
  assign do_wr = wr_valid && !full;
  assign do_rd = rd_pop && !empty;
  assign full = (count_reg == AW'(0) + (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);

  // Storage
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_reg[wptr_reg] <= wr_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= wptr_reg + AW'(1);
      end
      if (do_rd) begin
        rptr_reg <= rptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Registered head of queue
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rptr_reg];
    end
  end
endmodule : sfsf_rx_fifo
`default_nettype wire

// file: rtl/sfsf_status.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sfsf_status #(
  parameter int DATA_W = 8,
  parameter int COUNT_W = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver side
  input wire logic rx_done,
  input wire logic [DATA_W-1:0] rx_char,
  output logic rx_hold,
  // Transmitter side
  input wire logic tx_sent,
  // Other status sources, from outside the clock domain
  input wire logic rx_err_evt,
  input wire logic tx_empty_evt,
  input wire logic break_evt,
  input wire logic rx_full_evt,
  input wire logic data_ready_evt,
  input wire logic tx_end_lvl,
  input wire logic framing_lvl,
  input wire logic parity_lvl,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] serial_status_reg;
  logic [15:0] serial_status_next;
  logic [15:0] read_seen_reg;
  logic [15:0] read_seen_next;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [COUNT_W-1:0] transmit_stop_count_reg;
  logic [COUNT_W-1:0] tx_count_reg;
  logic [31:0] serial_control_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_status_reg;
  logic [DATA_W-1:0] receive_fifo_data;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_pop;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic receive_enable_bit;
  logic overrun_set;
  logic tx_stop_set;
  logic [7:0] ext_raw;
  logic [7:0] ext_sync;
  logic [4:0] evt_prev_reg;
  logic [4:0] evt_rise;
  logic [15:0] status_view;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign ext_raw = {rx_err_evt, tx_empty_evt, break_evt, rx_full_evt, data_ready_evt,
                    tx_end_lvl, framing_lvl, parity_lvl};

  // One synchroniser per external status line; transmit-end idles high
  for (genvar i = 0; i < 8; i++) begin : g_sync
    sfsf_sync #(
      .RESET_VAL((i == 2) ? 1'b1 : 1'b0)
    ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .din(ext_raw[i]),
      .dout(ext_sync[i])
    );
  end

  // Rising edges of the event inputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      evt_prev_reg <= '0;
    end else begin
      evt_prev_reg <= ext_sync[7:3];
    end
  end
  assign evt_rise = ext_sync[7:3] & ~evt_prev_reg;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign addr_ok = (paddr == sfsf_pkg::SERIAL_STATUS_ADDR) || (paddr == sfsf_pkg::STOP_COUNT_ADDR) ||
                   (paddr == sfsf_pkg::CONTROL_ADDR) || (paddr == sfsf_pkg::IRQ_STATUS_ADDR) ||
                   (paddr == sfsf_pkg::IRQ_MASK_ADDR) || (paddr == sfsf_pkg::FIFO_DATA_ADDR) ||
                   (paddr == sfsf_pkg::TX_COUNT_ADDR);
  assign pslverr = psel && penable && !addr_ok;
  assign receive_enable_bit = serial_control_reg[sfsf_pkg::CTRL_RX_EN_BIT];

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  // Overrun: character completes while FIFO is full, async mode only
  assign overrun_set = rx_done && fifo_full && receive_enable_bit &&
                       serial_control_reg[sfsf_pkg::CTRL_ASYNC_BIT];
  assign rx_hold = serial_status_reg[sfsf_pkg::OVERRUN_BIT] || !receive_enable_bit;
  assign fifo_pop = rd_acc && (paddr == sfsf_pkg::FIFO_DATA_ADDR);

  sfsf_rx_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wr_valid(rx_done && !rx_hold),
    .wr_data(rx_char),
    .rd_pop(fifo_pop),
    .rd_data(receive_fifo_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // ----------------------------------------------------------------
  // Transmit-stop counting
  // ----------------------------------------------------------------
  // Counts sent characters; cleared when software clears the flag
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_count_reg <= '0;
    end else if (clr_vec[sfsf_pkg::TX_STOP_BIT]) begin
      tx_count_reg <= '0;
    end else if (tx_sent) begin
      tx_count_reg <= tx_count_reg + COUNT_W'(1);
    end
  end
  // Pulse on the character that reaches the stop value, so a clear is not undone
  assign tx_stop_set = tx_sent && (transmit_stop_count_reg != '0) &&
                       ((tx_count_reg + COUNT_W'(1)) == transmit_stop_count_reg);

  // ----------------------------------------------------------------
  // Serial status flags
  // ----------------------------------------------------------------
  // Set sources; writes never add to this
  always_comb begin
    set_vec = '0;
    set_vec[sfsf_pkg::OVERRUN_BIT] = overrun_set;
    set_vec[sfsf_pkg::TX_STOP_BIT] = tx_stop_set;
    set_vec[sfsf_pkg::RX_ERR_BIT] = evt_rise[4];
    set_vec[sfsf_pkg::TX_EMPTY_BIT] = evt_rise[3];
    set_vec[sfsf_pkg::BREAK_BIT] = evt_rise[2];
    set_vec[sfsf_pkg::RX_FULL_BIT] = evt_rise[1];
    set_vec[sfsf_pkg::DATA_READY_BIT] = evt_rise[0];
  end

  // Clear only bits written zero after being read as one
  assign clr_vec = (wr_acc && paddr == sfsf_pkg::SERIAL_STATUS_ADDR) ?
                   (~pwdata[15:0] & read_seen_reg & sfsf_pkg::CLEARABLE_MASK) : 16'h0000;

  // Next flag value; set wins over clear, receive-enable has no effect
  always_comb begin
    serial_status_next = (serial_status_reg & ~clr_vec) | set_vec;
    serial_status_next = serial_status_next & sfsf_pkg::CLEARABLE_MASK;
  end

  // Flag storage, zero on reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      serial_status_reg <= '0;
    end else begin
      serial_status_reg <= serial_status_next;
    end
  end

  // Read-as-one memory, dropped once the flag is gone
  always_comb begin
    read_seen_next = read_seen_reg & serial_status_next;
    if (rd_acc && paddr == sfsf_pkg::SERIAL_STATUS_ADDR) begin
      read_seen_next = read_seen_next | (serial_status_reg & serial_status_next);
    end
    if (wr_acc && paddr == sfsf_pkg::SERIAL_STATUS_ADDR) begin
      read_seen_next = read_seen_next & ~clr_vec;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      read_seen_reg <= '0;
    end else begin
      read_seen_reg <= read_seen_next;
    end
  end

  // Read view merges read-only levels; top bits zero
  always_comb begin
    status_view = serial_status_reg;
    status_view[sfsf_pkg::TX_END_BIT] = ext_sync[2];
    status_view[sfsf_pkg::FRAMING_BIT] = ext_sync[1];
    status_view[sfsf_pkg::PARITY_BIT] = ext_sync[0];
    status_view[15:10] = '0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      serial_control_reg <= sfsf_pkg::CTRL_RESET;
    end else if (wr_acc && paddr == sfsf_pkg::CONTROL_ADDR) begin
      serial_control_reg <= {30'h0000_0000, pwdata[1:0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      transmit_stop_count_reg <= '0;
    end else if (wr_acc && paddr == sfsf_pkg::STOP_COUNT_ADDR) begin
      transmit_stop_count_reg <= pwdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_mask_reg <= '0;
    end else if (wr_acc && paddr == sfsf_pkg::IRQ_MASK_ADDR) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~((wr_acc && paddr == sfsf_pkg::IRQ_STATUS_ADDR) ? pwdata[1:0] : 2'h0)) |
                        {tx_stop_set, overrun_set};
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      sfsf_pkg::SERIAL_STATUS_ADDR: prdata = {16'h0000, status_view};
      sfsf_pkg::STOP_COUNT_ADDR: prdata = 32'(transmit_stop_count_reg);
      sfsf_pkg::CONTROL_ADDR: prdata = serial_control_reg;
      sfsf_pkg::IRQ_STATUS_ADDR: prdata = {30'h0000_0000, irq_status_reg};
      sfsf_pkg::IRQ_MASK_ADDR: prdata = {30'h0000_0000, irq_mask_reg};
      sfsf_pkg::FIFO_DATA_ADDR: prdata = fifo_empty ? 32'h0000_0000 : 32'(receive_fifo_data);
      sfsf_pkg::TX_COUNT_ADDR: prdata = 32'(tx_count_reg);
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule : sfsf_status
`default_nettype wire

// file: testbench/sfsf_status_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the status block
// ----------------------------------------
module sfsf_status_chk #(
  parameter int DATA_W = 8,
  parameter int COUNT_W = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_done,
  input wire logic [DATA_W-1:0] rx_char,
  input wire logic rx_hold,
  input wire logic tx_sent,
  input wire logic rx_err_evt,
  input wire logic tx_empty_evt,
  input wire logic break_evt,
  input wire logic rx_full_evt,
  input wire logic data_ready_evt,
  input wire logic tx_end_lvl,
  input wire logic framing_lvl,
  input wire logic parity_lvl,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Access phase and read decodes
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic rd_st = rd && paddr == sfsf_pkg::SERIAL_STATUS_ADDR;
  ready_high_a: assert property (acc |-> pready) else $error("pready low in access phase");
  err_unmapped_a: assert property (acc && paddr > 8'h18 |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  err_mapped_a: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  err_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access phase");
  rsv_zero_a: assert property (rd_st |-> prdata[31:10] == 22'h00_0000) else $error("reserved bits nonzero");
  ovr_hold_a: assert property (rd_st && prdata[9] |-> rx_hold) else $error("reception runs during overrun");
  off_hold_a: assert property (rd && paddr == sfsf_pkg::CONTROL_ADDR && !prdata[0] |-> rx_hold)
    else $error("reception runs while disabled");
  rst_clear_a: assert property ($rose(rstn) |-> rx_hold && !irq) else $error("state after reset wrong");
  irq_mask_a: assert property (rd && paddr == sfsf_pkg::IRQ_MASK_ADDR && prdata[1:0] == 2'b00 |-> !irq)
    else $error("irq with all masked");
endmodule : sfsf_status_chk
bind sfsf_status sfsf_status_chk #(.DATA_W(DATA_W), .COUNT_W(COUNT_W), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (.*);
`default_nettype wire

// file: testbench/sfsf_remote_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Remote station: character events
// ----------------------------------------
module sfsf_remote_model (
  input wire logic sys_clk,
  output logic rx_done,
  output logic [7:0] rx_char,
  output logic tx_sent
);
  initial begin
    rx_done = 1'b0;
    rx_char = 8'h5A;
    tx_sent = 1'b0;
  end
  // Deliver n characters; data is idle-inverted between them
  task automatic send_rx(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_done <= 1'b1;
      rx_char <= 8'(i);
      @(posedge sys_clk);
      rx_done <= 1'b0;
      rx_char <= ~8'(i);
      repeat (gap) @(posedge sys_clk);
    end
  endtask : send_rx
  // Acknowledge n transmitted characters
  task automatic send_tx(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      tx_sent <= 1'b1;
      @(posedge sys_clk);
      tx_sent <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask : send_tx
endmodule : sfsf_remote_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ST = sfsf_pkg::SERIAL_STATUS_ADDR;
  localparam logic [7:0] CT = sfsf_pkg::CONTROL_ADDR;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, rx_done, rx_hold, tx_sent, irq;
  logic [7:0] paddr, rx_char;
  logic [31:0] pwdata, prdata, r;
  logic [4:0] ev;
  logic [2:0] lv;
  int n_fail, compares;
  int ebit[5] = '{0, 1, 4, 5, 7};
  // ----------------------------------------
  // Clock, design and remote station
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  sfsf_status dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_done(rx_done), .rx_char(rx_char), .rx_hold(rx_hold), .tx_sent(tx_sent),
    .rx_err_evt(ev[4]), .tx_empty_evt(ev[3]), .break_evt(ev[2]), .rx_full_evt(ev[1]),
    .data_ready_evt(ev[0]), .tx_end_lvl(lv[2]), .framing_lvl(lv[1]), .parity_lvl(lv[0]), .irq(irq));
  sfsf_remote_model m_u (.sys_clk(sys_clk), .rx_done(rx_done), .rx_char(rx_char), .tx_sent(tx_sent));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    if (k >= 50) begin
      n_fail++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("read", e, r);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_ones;
    apb(1'b1, ST, 32'h0000_03FF);
    rd(ST, 32'h0000_0040);
  endtask : t_write_ones
  task automatic t_events;
    for (int i = 0; i < 5; i++) begin
      ev[i] <= 1'b1;
      wt(8);
      ev <= 5'h00;
      wt(8);
      rd(ST, 32'h0000_0040 | (32'h0000_0001 << ebit[i]));
      apb(1'b1, ST, 32'h0000_0000);
      rd(ST, 32'h0000_0040);
    end
  endtask : t_events
  task automatic t_levels;
    lv <= 3'b011;
    wt(8);
    rd(ST, 32'h0000_000C);
    apb(1'b1, ST, 32'h0000_0000);
    rd(ST, 32'h0000_000C);
    lv <= 3'b100;
    wt(8);
  endtask : t_levels
  task automatic t_tx_stop;
    apb(1'b1, sfsf_pkg::STOP_COUNT_ADDR, 32'h0000_0002);
    m_u.send_tx(2, 3);
    wt(4);
    apb(1'b1, ST, 32'h0000_0000);
    rd(ST, 32'h0000_0140);
    apb(1'b1, ST, 32'h0000_0100);
    rd(ST, 32'h0000_0140);
    apb(1'b1, ST, 32'h0000_0000);
    rd(ST, 32'h0000_0040);
  endtask : t_tx_stop
  task automatic t_overrun;
    apb(1'b1, CT, 32'h0000_0003);
    m_u.send_rx(17, 2);
    wt(4);
    rd(ST, 32'h0000_0240);
    chk("hold", 32'h1, {31'h0, rx_hold});
    chk("irq masked", 32'h0, {31'h0, irq});
    for (int i = 0; i < 16; i++) begin
      rd(sfsf_pkg::FIFO_DATA_ADDR, 32'(i));
    end
    rd(sfsf_pkg::FIFO_DATA_ADDR, 32'h0000_0000);
    apb(1'b1, CT, 32'h0000_0002);
    rd(ST, 32'h0000_0240);
    apb(1'b1, sfsf_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
    wt(1);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, sfsf_pkg::IRQ_STATUS_ADDR, 32'h0000_0003);
    wt(1);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1'b1, ST, 32'h0000_0000);
    rd(ST, 32'h0000_0040);
    apb(1'b1, CT, 32'h0000_0003);
    wt(1);
    chk("resume", 32'h0, {31'h0, rx_hold});
  endtask : t_overrun
  task automatic t_mid_reset;
    apb(1'b1, sfsf_pkg::STOP_COUNT_ADDR, 32'h0000_0001);
    m_u.send_tx(1, 0);
    wt(4);
    rstn <= 1'b0;
    wt(2);
    rstn <= 1'b1;
    rd(ST, 32'h0000_0040);
    rd(CT, 32'h0000_0002);
    rd(8'h20, 32'h0000_0000);
  endtask : t_mid_reset
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    stop_test;
  end
  // Reset, then each scenario in turn
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ev = 5'h00;
    lv = 3'b100;
    wt(10);
    rstn <= 1'b1;
    rd(ST, 32'h0000_0040);
    t_write_ones;
    t_events;
    t_levels;
    t_tx_stop;
    t_overrun;
    t_mid_reset;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
